// ---- host_port_model.sv ----
// Host model: register commands and the fast shutdown pin, driven at falling edges
`timescale 1ns/1ps
module host_port_model (
    // Clock and answer
    input wire clk_sys,
    input wire [7:0] cmd_rdata_q,
    input wire cmd_rvalid_q,
    // Command port
    output reg [7:0] cmd_addr,
    output reg [7:0] cmd_wdata,
    output reg cmd_wr,
    output reg cmd_rd,
    // Pin and mode
    output reg fast_shutdown_input,
    output reg multi_level_priority_enable
);
    initial begin
        cmd_addr = 8'h00;
        cmd_wdata = 8'h00;
        cmd_wr = 1'b0;
        cmd_rd = 1'b0;
        fast_shutdown_input = 1'b0;
        multi_level_priority_enable = 1'b0;
    end
    // Idle bus shows inverted values so stale data never passes for fresh
    task write_reg(input [7:0] a, input [7:0] d);
        begin
            @(negedge clk_sys);
            cmd_addr = a;
            cmd_wdata = d;
            cmd_wr = 1'b1;
            @(negedge clk_sys);
            cmd_wr = 1'b0;
            cmd_addr = ~a;
            cmd_wdata = ~d;
        end
    endtask
    task read_reg(input [7:0] a, output [7:0] d);
        begin
            @(negedge clk_sys);
            cmd_addr = a;
            cmd_rd = 1'b1;
            @(negedge clk_sys);
            cmd_rd = 1'b0;
            cmd_addr = ~a;
            d = (cmd_rvalid_q === 1'b1) ? cmd_rdata_q : 8'hxx;
        end
    endtask
    // Priority bits are cleared before multi level mode is raised
    task set_multi_level(input on);
        reg [7:0] v;
        begin
            read_reg(8'h15, v);
            if (on) begin
                write_reg(8'h15, v & 8'h0f);
            end
            @(negedge clk_sys);
            multi_level_priority_enable = on;
        end
    endtask
    task pulse_shutdown(input integer n);
        begin
            @(negedge clk_sys);
            fast_shutdown_input = 1'b1;
            repeat (n) @(negedge clk_sys);
            fast_shutdown_input = 1'b0;
        end
    endtask
endmodule // host_port_model

// ---- pin_sync.v ----
// Two-stage synchroniser for an asynchronous input pin
`timescale 1ns/1ps
module pin_sync (
    // Clock and reset
    input wire clk_sys,
    input wire rst,
    // Pin in, clean level out
    input wire pin_in,
    output reg level_q
);
    // ==========================================================
    // Synchroniser
    reg meta_q; // First stage, read only by the second stage

    // Two flops; the first may go metastable
    always @(posedge clk_sys) begin
        if (rst) begin
            meta_q <= 1'b0;
            level_q <= 1'b0;
        end else begin
            meta_q <= pin_in;
            level_q <= meta_q;
        end
    end
endmodule // pin_sync

// ---- pse_cfg_sva.sv ----
// Concurrent checks on the shutdown priority and timing block ports
`timescale 1ns/1ps
`include "pse_consts.vh"
module pse_cfg_sva #(
    parameter CHANNELS = 4,
    parameter TICK_CYCLES = 10
) (
    // Clock and reset
    input wire clk_sys,
    input wire rst,
    // Register port
    input wire [7:0] cmd_addr,
    input wire cmd_wr,
    input wire cmd_rd,
    input wire [7:0] cmd_rdata_q,
    input wire cmd_rvalid_q,
    // Shutdown and fault side
    input wire multi_level_priority_enable,
    input wire [CHANNELS-1:0] shutdown_off_q,
    input wire [CHANNELS-1:0] cut_off_q,
    input wire [CHANNELS-1:0] cut_flag_set_q,
    input wire clear_strobe_q,
    input wire [3:0] clear_group_q,
    input wire [CHANNELS-1:0] clear_mask_q,
    input wire [7:0] clear_value_q,
    // Timing fields
    input wire [1:0] limit_time_select,
    input wire [1:0] startup_time_select,
    input wire [1:0] overload_time_select,
    input wire [1:0] maintain_dropout_time_select
);
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (rst);
    // ==========================================================
    // Walk steps: first group carries the shutdown mask, then groups count up
    sequence walk_head;
        clear_strobe_q && clear_group_q == 4'h0 && clear_mask_q == $past(shutdown_off_q);
    endsequence
    sequence walk_step;
        clear_strobe_q && clear_group_q == $past(clear_group_q) + 4'h1
            && clear_mask_q == $past(clear_mask_q);
    endsequence
    a_walk_start: assert property (|shutdown_off_q |=> walk_head)
        else $error("clear walk did not start after shutdown");
    a_walk_advance: assert property (clear_strobe_q && clear_group_q != `CLR_LAST
        |=> walk_step)
        else $error("clear walk skipped a group or changed mask");
    a_walk_stops: assert property (clear_strobe_q && clear_group_q == `CLR_LAST
        |=> !clear_strobe_q)
        else $error("clear walk ran past last group");
    a_police_value: assert property (clear_strobe_q |->
        clear_value_q == ((clear_group_q == `CLR_POLICE) ? 8'hff : 8'h00))
        else $error("wrong clear value for group");
    // ==========================================================
    // Shutdown and overload outputs
    a_shutdown_mode: assert property (|shutdown_off_q
        |-> !$past(multi_level_priority_enable))
        else $error("shutdown while multi level mode set");
    a_shutdown_pulse: assert property (|shutdown_off_q |=> shutdown_off_q == 4'h0)
        else $error("shutdown request longer than one cycle");
    a_cut_with_flag: assert property (|cut_off_q
        |-> (cut_off_q & ~cut_flag_set_q) == 4'h0)
        else $error("cut turn off without fault flag");
    // ==========================================================
    // Register port answers
    a_read_answer: assert property (cmd_rd |=> cmd_rvalid_q)
        else $error("read not answered next cycle");
    a_unmapped_zero: assert property (cmd_rd && cmd_addr != `PRIO_CUT_ADDR
        && cmd_addr != `TIMING_ADDR |=> cmd_rdata_q == 8'h00)
        else $error("unmapped read not zero");
    a_fields_follow: assert property ($changed({limit_time_select,
        startup_time_select, overload_time_select, maintain_dropout_time_select})
        |-> $past(cmd_wr && cmd_addr == `TIMING_ADDR, 2))
        else $error("timing fields moved without a write");
endmodule // pse_cfg_sva
bind pse_shutdown_priority_and_timing_cfg pse_cfg_sva #(.CHANNELS(CHANNELS),
    .TICK_CYCLES(TICK_CYCLES)) chk (.*);

// ---- pse_consts.vh ----
// Constants for the shutdown priority and fault timing configuration block
// What this block does
// - Fast shutdown powers off channels with priority set while multi-level mode is off
// - Cut disable blocks overload-cut turn off
// - Current limit monitoring continues despite cut disable
// - Overload-cut flag still raised after overload time
// - Cut disable bit change resets overload timer
// - Fast shutdown acts as reset, cool-down continues
// - Shutdown clears status, fault and enable bits
// - Shutdown clears channel measurement results
// - Shutdown clears class and detection results
// - Shutdown sets two-pair policing to all ones
// - All clearing finishes within five milliseconds
// - Only selected channels are cleared
// - One shared timing register, reset to zero
// - Limit field selects time before limit turn off
`ifndef PSE_CONSTS_VH
`define PSE_CONSTS_VH

// ==========================================================
// Register command codes and reset values
`define PRIO_CUT_ADDR 8'h15
`define TIMING_ADDR 8'h16
`define PRIO_CUT_RESET 8'h00
`define TIMING_RESET 8'h00
`define UNMAPPED_READ 8'h00

// ==========================================================
// Field positions
`define PRIO_MSB 7
`define PRIO_LSB 4
`define CUT_MSB 3
`define CUT_LSB 0
`define LIM_MSB 7
`define LIM_LSB 6
`define START_MSB 5
`define START_LSB 4
`define OVLD_MSB 3
`define OVLD_LSB 2
`define DROP_MSB 1
`define DROP_LSB 0

// ==========================================================
// Timing: clock rate, millisecond tick, selectable times in ms
`define CLK_KHZ 125000
`define TICK_MS 1
`define CLEAR_LIMIT_MS 5
`define LIM_MS_0 8'd60
`define LIM_MS_1 8'd30
`define LIM_MS_2 8'd120
`define LIM_MS_3 8'd240
`define OVLD_MS_0 8'd60
`define OVLD_MS_1 8'd30
`define OVLD_MS_2 8'd120
`define OVLD_MS_3 8'd240

// ==========================================================
// Clear walk: register groups visited, policing group index
`define CLR_GROUPS 4'd14
`define CLR_LAST 4'd13
`define CLR_POLICE 4'd9
`define POLICE_VALUE 8'hff
`define CLEAR_VALUE 8'h00

`endif

// ---- pse_shutdown_priority_and_timing_cfg.v ----
// Shutdown priority, overload-cut disable and fault timing configuration
`timescale 1ns/1ps
`include "pse_consts.vh"
module pse_shutdown_priority_and_timing_cfg #(
    parameter CHANNELS = 4,
    parameter TICK_CYCLES = (`CLK_KHZ * `TICK_MS)
) (
    // Clock and reset
    input wire clk_sys,
    input wire rst,
    // Register command port behind the serial front end
    input wire [7:0] cmd_addr,
    input wire [7:0] cmd_wdata,
    input wire cmd_wr,
    input wire cmd_rd,
    output reg [7:0] cmd_rdata_q,
    output reg cmd_rvalid_q,
    // External fast shutdown pin and mode
    input wire fast_shutdown_input,
    input wire multi_level_priority_enable,
    // Fault levels from the channel monitors
    input wire [CHANNELS-1:0] overload_cut_fault,
    input wire [CHANNELS-1:0] current_limit_fault,
    // Channel turn off requests and overload-cut flag, one-cycle pulses
    output reg [CHANNELS-1:0] shutdown_off_q,
    output reg [CHANNELS-1:0] cut_off_q,
    output reg [CHANNELS-1:0] limit_off_q,
    output reg [CHANNELS-1:0] cut_flag_set_q,
    // Clear walk towards the channel state registers
    output reg clear_strobe_q,
    output reg [3:0] clear_group_q,
    output reg [CHANNELS-1:0] clear_mask_q,
    output reg [7:0] clear_value_q,
    output reg clear_busy_q,
    // Shared timing fields
    output reg [1:0] limit_time_select,
    output reg [1:0] startup_time_select,
    output reg [1:0] overload_time_select,
    output reg [1:0] maintain_dropout_time_select
);
    // ==========================================================
    // Declarations
    localparam ST_IDLE = 1'b0; // Waiting for a shutdown edge
    localparam ST_WALK = 1'b1; // Stepping through register groups
    localparam integer TICK_LAST_I = TICK_CYCLES - 1; // Prescaler wrap, full width
    // Cut on purpose to the counter width; ticks above 131072 cycles do not fit
    localparam [16:0] TICK_LAST = TICK_LAST_I[16:0];

    reg [7:0] prio_cut_q; // Priority and cut disable bits
    reg [7:0] timing_q; // Shared timing fields
    reg [CHANNELS-1:0] cut_dis_last_q; // Cut bits one cycle ago
    reg shut_last_q; // Synchronised shutdown one cycle ago
    reg walk_state_q; // Clear walk state
    reg [3:0] walk_idx_q; // Group being cleared
    reg [CHANNELS-1:0] walk_mask_q; // Channels being cleared
    reg [16:0] tick_cnt_q; // Millisecond prescaler
    reg tick_q; // One-cycle tick each millisecond
    reg [7:0] ovld_ms; // Overload timeout in ms
    reg [7:0] lim_ms; // Current limit timeout in ms
    wire shut_lvl; // Synchronised shutdown level
    wire shut_edge; // Rising edge of the shutdown level
    wire [CHANNELS-1:0] prio_bits; // Channels chosen for shutdown
    wire [CHANNELS-1:0] cut_dis; // Overload-cut disable per channel
    wire [CHANNELS-1:0] cut_dis_chg; // Cut disable changed this cycle
    wire [CHANNELS-1:0] shut_sel; // Channels hit by this edge
    wire [CHANNELS-1:0] chan_dn; // Channels turned off last cycle
    wire [CHANNELS-1:0] ovld_exp; // Overload timer expires now
    wire [CHANNELS-1:0] lim_exp; // Limit timer expires now

    assign prio_bits = prio_cut_q[`PRIO_MSB:`PRIO_LSB];
    assign cut_dis = prio_cut_q[`CUT_MSB:`CUT_LSB];
    assign cut_dis_chg = cut_dis ^ cut_dis_last_q;
    assign shut_edge = shut_lvl & ~shut_last_q;
    // In multi-level mode the single-bit path stays out of the way
    assign shut_sel = multi_level_priority_enable ? {CHANNELS{1'b0}} : prio_bits;
    assign chan_dn = shutdown_off_q | cut_off_q | limit_off_q;

    // ==========================================================
    // Fast shutdown pin synchroniser
    pin_sync u_shut_sync (
        .clk_sys(clk_sys),
        .rst(rst),
        .pin_in(fast_shutdown_input),
        .level_q(shut_lvl)
    );

    // ==========================================================
    // Register writes and reads
    // Writes take effect the cycle after cmd_wr; reads answer one cycle later
    always @(posedge clk_sys) begin
        if (rst) begin
            prio_cut_q <= `PRIO_CUT_RESET;
            timing_q <= `TIMING_RESET;
            cmd_rdata_q <= `UNMAPPED_READ;
            cmd_rvalid_q <= 1'b0;
        end else begin
            // Priority bits are stored as written; the host keeps them zero
            // while multi-level mode is on, so no gating is done here
            if (cmd_wr && cmd_addr == `PRIO_CUT_ADDR) begin
                prio_cut_q <= cmd_wdata;
            end else if (cmd_wr && cmd_addr == `TIMING_ADDR) begin
                timing_q <= cmd_wdata;
            end
            cmd_rvalid_q <= cmd_rd;
            if (cmd_rd && cmd_addr == `PRIO_CUT_ADDR) begin
                cmd_rdata_q <= prio_cut_q;
            end else if (cmd_rd && cmd_addr == `TIMING_ADDR) begin
                cmd_rdata_q <= timing_q;
            end else if (cmd_rd) begin
                // Unknown codes read as zero
                cmd_rdata_q <= `UNMAPPED_READ;
            end
        end
    end

    // ==========================================================
    // Timing field outputs, registered copies of the shared register
    always @(posedge clk_sys) begin
        if (rst) begin
            limit_time_select <= 2'h0;
            startup_time_select <= 2'h0;
            overload_time_select <= 2'h0;
            maintain_dropout_time_select <= 2'h0;
        end else begin
            limit_time_select <= timing_q[`LIM_MSB:`LIM_LSB];
            startup_time_select <= timing_q[`START_MSB:`START_LSB];
            overload_time_select <= timing_q[`OVLD_MSB:`OVLD_LSB];
            maintain_dropout_time_select <= timing_q[`DROP_MSB:`DROP_LSB];
        end
    end

    // ==========================================================
    // Timeout lookup from the timing fields
    always @* begin
        case (timing_q[`LIM_MSB:`LIM_LSB])
            2'h0: lim_ms = `LIM_MS_0;
            2'h1: lim_ms = `LIM_MS_1;
            2'h2: lim_ms = `LIM_MS_2;
            default: lim_ms = `LIM_MS_3;
        endcase
        case (timing_q[`OVLD_MSB:`OVLD_LSB])
            2'h0: ovld_ms = `OVLD_MS_0;
            2'h1: ovld_ms = `OVLD_MS_1;
            2'h2: ovld_ms = `OVLD_MS_2;
            default: ovld_ms = `OVLD_MS_3;
        endcase
    end

    // ==========================================================
    // Millisecond prescaler shared by every channel timer
    always @(posedge clk_sys) begin
        if (rst) begin
            tick_cnt_q <= 17'h00000;
            tick_q <= 1'b0;
        end else if (tick_cnt_q == TICK_LAST) begin
            tick_cnt_q <= 17'h00000;
            tick_q <= 1'b1;
        end else begin
            tick_cnt_q <= tick_cnt_q + 17'h00001;
            tick_q <= 1'b0;
        end
    end

    // ==========================================================
    // Per-channel overload and current limit timers
    // A timer stops at its limit; the turn off pulse clears it, so a held fault fires again unless cut disable blocks the turn off
    genvar g;
    generate
        for (g = 0; g < CHANNELS; g = g + 1) begin : chan
            reg [7:0] ovld_cnt_q; // Overload time in ms
            reg [7:0] lim_cnt_q; // Current limit time in ms

            assign ovld_exp[g] = tick_q & overload_cut_fault[g] & ~cut_dis_chg[g] &
                                 (ovld_cnt_q == ovld_ms - 8'h01);
            assign lim_exp[g] = tick_q & current_limit_fault[g] &
                                (lim_cnt_q == lim_ms - 8'h01);

            // Overload timer, restarted whenever the cut disable bit moves
            always @(posedge clk_sys) begin
                if (rst) begin
                    ovld_cnt_q <= 8'h00;
                end else if (cut_dis_chg[g]) begin
                    ovld_cnt_q <= 8'h00;
                end else if (!overload_cut_fault[g] || chan_dn[g]) begin
                    ovld_cnt_q <= 8'h00;
                end else if (tick_q && ovld_cnt_q < ovld_ms) begin
                    ovld_cnt_q <= ovld_cnt_q + 8'h01;
                end
            end

            // Limit timer runs regardless of the cut disable bit
            always @(posedge clk_sys) begin
                if (rst) begin
                    lim_cnt_q <= 8'h00;
                end else if (!current_limit_fault[g] || chan_dn[g]) begin
                    lim_cnt_q <= 8'h00;
                end else if (tick_q && lim_cnt_q < lim_ms) begin
                    lim_cnt_q <= lim_cnt_q + 8'h01;
                end
            end
        end
    endgenerate

    // ==========================================================
    // Fault turn off and flag pulses
    always @(posedge clk_sys) begin
        if (rst) begin
            cut_off_q <= {CHANNELS{1'b0}};
            limit_off_q <= {CHANNELS{1'b0}};
            cut_flag_set_q <= {CHANNELS{1'b0}};
            cut_dis_last_q <= {CHANNELS{1'b0}};
        end else begin
            cut_dis_last_q <= cut_dis;
            // The flag is raised even when turn off is blocked
            cut_flag_set_q <= ovld_exp;
            cut_off_q <= ovld_exp & ~cut_dis;
            limit_off_q <= lim_exp;
        end
    end

    // ==========================================================
    // Fast shutdown edge and immediate turn off
    // Cool-down timers live with the channel sequencer and are not touched
    // here, so a shutdown lets any running cool-down finish
    always @(posedge clk_sys) begin
        if (rst) begin
            shut_last_q <= 1'b0;
            shutdown_off_q <= {CHANNELS{1'b0}};
        end else begin
            shut_last_q <= shut_lvl;
            if (shut_edge) begin
                shutdown_off_q <= shut_sel;
            end else begin
                shutdown_off_q <= {CHANNELS{1'b0}};
            end
        end
    end

    // ==========================================================
    // Clear walk: one register group per cycle, masked per channel
    // Fourteen cycles finish far inside the five millisecond budget
    always @(posedge clk_sys) begin
        if (rst) begin
            walk_state_q <= ST_IDLE;
            walk_idx_q <= 4'h0;
            walk_mask_q <= {CHANNELS{1'b0}};
        end else begin
            case (walk_state_q)
                ST_IDLE: begin
                    if (shut_edge && shut_sel != {CHANNELS{1'b0}}) begin
                        walk_state_q <= ST_WALK;
                        walk_idx_q <= 4'h0;
                        walk_mask_q <= shut_sel;
                    end
                end
                default: begin
                    if (shut_edge) begin
                        // A new edge mid-walk widens the mask and starts over
                        walk_idx_q <= 4'h0;
                        walk_mask_q <= walk_mask_q | shut_sel;
                    end else if (walk_idx_q == `CLR_LAST) begin
                        walk_state_q <= ST_IDLE;
                        walk_idx_q <= 4'h0;
                        walk_mask_q <= {CHANNELS{1'b0}};
                    end else begin
                        walk_idx_q <= walk_idx_q + 4'h1;
                    end
                end
            endcase
        end
    end

    // ==========================================================
    // Clear strobe outputs towards the channel state registers
    // Groups 0-8 cover event, fault, status and enable bits, 10-13 the
    // measurement and class results; group 9 is policing, set to all ones
    always @(posedge clk_sys) begin
        if (rst) begin
            clear_strobe_q <= 1'b0;
            clear_group_q <= 4'h0;
            clear_mask_q <= {CHANNELS{1'b0}};
            clear_value_q <= `CLEAR_VALUE;
            clear_busy_q <= 1'b0;
        end else begin
            clear_busy_q <= (walk_state_q == ST_WALK) && !(walk_idx_q == `CLR_LAST && !shut_edge);
            if (walk_state_q == ST_WALK) begin
                clear_strobe_q <= 1'b1;
                clear_group_q <= walk_idx_q;
                clear_mask_q <= walk_mask_q;
                if (walk_idx_q == `CLR_POLICE) begin
                    clear_value_q <= `POLICE_VALUE;
                end else begin
                    clear_value_q <= `CLEAR_VALUE;
                end
            end else begin
                clear_strobe_q <= 1'b0;
                clear_group_q <= 4'h0;
                clear_mask_q <= {CHANNELS{1'b0}};
                clear_value_q <= `CLEAR_VALUE;
            end
        end
    end
endmodule // pse_shutdown_priority_and_timing_cfg

// ---- pse_shutdown_priority_and_timing_cfg_bench.sv ----
// Self-checking bench for the shutdown priority and timing block
`timescale 1ns/1ps
`include "pse_consts.vh"
module pse_shutdown_priority_and_timing_cfg_bench;
    localparam CHANNELS = 4;
    localparam TICK_CYCLES = 10; // Shortened millisecond tick
    reg clk_sys = 1'b0;
    reg rst = 1'b1;
    reg [3:0] overload_cut_fault = 4'h0;
    reg [3:0] current_limit_fault = 4'h0;
    wire [7:0] cmd_addr, cmd_wdata, cmd_rdata_q, clear_value_q;
    wire cmd_wr, cmd_rd, cmd_rvalid_q, fast_shutdown_input, multi_level_priority_enable;
    wire [3:0] shutdown_off_q, cut_off_q, limit_off_q, cut_flag_set_q, clear_mask_q;
    wire clear_strobe_q, clear_busy_q;
    wire [3:0] clear_group_q;
    wire [1:0] limit_time_select, startup_time_select;
    wire [1:0] overload_time_select, maintain_dropout_time_select;
    integer err_total = 0, total_checks = 0, cycles = 0, walk_n = 0, i;
    reg [3:0] flag_seen, off_seen, lim_seen, sd_seen, exp_mask;
    reg [31:0] seed = 32'h2b2c;
    reg [7:0] d, v;
    pse_shutdown_priority_and_timing_cfg #(.CHANNELS(CHANNELS), .TICK_CYCLES(TICK_CYCLES)) DUT (.*);
    host_port_model host (.*);
    always #4 clk_sys = ~clk_sys;
    // ==========================================================
    // Helpers
    function [31:0] xs(input [31:0] s);
        reg [31:0] t;
        begin
            t = s ^ (s << 13);
            t = t ^ (t >> 17);
            xs = t ^ (t << 5);
        end
    endfunction
    function integer ms_of(input [1:0] sel);
        ms_of = (sel == 2'd0) ? 60 : (sel == 2'd1) ? 30 : (sel == 2'd2) ? 120 : 240;
    endfunction
    task check(input string what, input [7:0] seen, input [7:0] want);
        begin
            total_checks = total_checks + 1;
            if (seen !== want) begin
                err_total = err_total + 1;
                $display("[FAIL] %s expected %h seen %h", what, want, seen);
            end
        end
    endtask
    task close_out;
        begin
            $display("checks %0d mismatches %0d", total_checks, err_total);
            if (err_total == 0 && total_checks > 0) $display("== PASSED ==");
            else $display("== FAILED ==");
            $finish;
        end
    endtask
    // Hang guard well above the longest fault wait
    always @(posedge clk_sys) begin
        cycles = cycles + 1;
        if (cycles == 60000) begin
            err_total = err_total + 1;
            close_out;
        end
    end
    // Monitor at falling edges, where registered outputs have settled
    always @(negedge clk_sys) begin
        flag_seen = flag_seen | cut_flag_set_q;
        off_seen = off_seen | cut_off_q;
        lim_seen = lim_seen | limit_off_q;
        sd_seen = sd_seen | shutdown_off_q;
        if (clear_strobe_q === 1'b1) begin
            check("clear_group", {4'h0, clear_group_q}, walk_n[7:0]);
            check("clear_mask", {4'h0, clear_mask_q}, {4'h0, exp_mask});
            check("clear_value", clear_value_q, (walk_n == 9) ? 8'hff : 8'h00);
            // Busy stays up while more strobes follow, so it is low on the last group
            check("clear_busy", {7'h0, clear_busy_q}, {7'h0, walk_n != 13});
            walk_n = walk_n + 1;
        end
    end
    // ==========================================================
    // Scenarios
    task shutdown_case(input [3:0] prio, input mode);
        begin
            host.write_reg(`PRIO_CUT_ADDR, {prio, 4'h0});
            host.set_multi_level(mode);
            sd_seen = 4'h0;
            walk_n = 0;
            exp_mask = mode ? 4'h0 : prio;
            host.pulse_shutdown(3);
            repeat (26) @(negedge clk_sys);
            check("shutdown_off", {4'h0, sd_seen}, {4'h0, exp_mask});
            check("walk_len", walk_n[7:0], (exp_mask == 4'h0) ? 8'd0 : 8'd14);
            host.set_multi_level(1'b0);
        end
    endtask
    // Fault held on all channels; flag lands between n-1 and n ticks
    task fault_case(input [1:0] sel, input [3:0] dis, input lim);
        integer n;
        begin
            host.write_reg(`TIMING_ADDR, {sel, 2'b00, sel, 2'b00});
            host.write_reg(`PRIO_CUT_ADDR, {4'h0, dis});
            n = ms_of(sel);
            flag_seen = 4'h0;
            off_seen = 4'h0;
            lim_seen = 4'h0;
            @(negedge clk_sys);
            if (lim) current_limit_fault = 4'hf;
            else overload_cut_fault = 4'hf;
            repeat ((n - 1) * TICK_CYCLES - 3) @(negedge clk_sys);
            check("early_flag", {4'h0, flag_seen | lim_seen}, 8'h00);
            repeat (TICK_CYCLES + 6) @(negedge clk_sys);
            if (lim) check("limit_off", {4'h0, lim_seen}, 8'h0f);
            else check("cut_flag", {4'h0, flag_seen}, 8'h0f);
            if (!lim) check("cut_off", {4'h0, off_seen}, {4'h0, ~dis});
            overload_cut_fault = 4'h0;
            current_limit_fault = 4'h0;
        end
    endtask
    initial begin
        repeat (10) @(negedge clk_sys);
        rst = 1'b0;
        host.read_reg(`PRIO_CUT_ADDR, d);
        check("prio_reset", d, 8'h00);
        host.read_reg(`TIMING_ADDR, d);
        check("timing_reset", d, 8'h00);
        for (i = 0; i < 8; i = i + 1) begin
            seed = xs(seed);
            v = seed[7:0];
            host.write_reg(`TIMING_ADDR, v);
            host.write_reg(8'h17, ~v);
            host.read_reg(`TIMING_ADDR, d);
            check("timing_rw", d, v);
            check("fields", {limit_time_select, startup_time_select,
                overload_time_select, maintain_dropout_time_select}, v);
            host.read_reg(seed[15:8] | 8'h80, d);
            check("unmapped", d, 8'h00);
            host.write_reg(`PRIO_CUT_ADDR, seed[23:16]);
            host.read_reg(`PRIO_CUT_ADDR, d);
            check("prio_rw", d, seed[23:16]);
            shutdown_case(seed[27:24], 1'b0);
        end
        shutdown_case(4'hf, 1'b0);
        shutdown_case(4'h0, 1'b0);
        shutdown_case(4'ha, 1'b1);
        for (i = 0; i < 4; i = i + 1) begin
            seed = xs(seed);
            fault_case(i[1:0], seed[3:0], 1'b0);
            fault_case(i[1:0], 4'hf, 1'b1);
        end
        // Toggling the cut disable bit mid-count restarts the overload timer
        host.write_reg(`TIMING_ADDR, 8'h04);
        host.write_reg(`PRIO_CUT_ADDR, 8'h00);
        flag_seen = 4'h0;
        overload_cut_fault = 4'h1;
        repeat (20 * TICK_CYCLES) @(negedge clk_sys);
        host.write_reg(`PRIO_CUT_ADDR, 8'h01);
        repeat (20 * TICK_CYCLES) @(negedge clk_sys);
        check("restart_hold", {4'h0, flag_seen}, 8'h00);
        repeat (15 * TICK_CYCLES) @(negedge clk_sys);
        check("restart_fire", {4'h0, flag_seen}, 8'h01);
        overload_cut_fault = 4'h0;
        close_out;
    end
endmodule // pse_shutdown_priority_and_timing_cfg_bench
